// *** rtl/embs_bus.sv ***
// Purpose: external program/data memory bus: fetch strobe, address latch strobe,
//          multiplexed low address/data port, upper address port, data strobes
// Assumes: clk_in is four ticks per crystal clock; one bus period is 16 ticks
// Notes:   every strobe is registered, so all of them lag the phase by one tick alike
`timescale 1ns/1ns

module embs_bus #(
    parameter int POR_TICKS = embs_pkg::POR_TICKS
) (
    // clock, reset, enable
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        ce_in,
    // reset pin, active high, asynchronous to clk_in
    input  wire logic        reset_pin_in,
    // request from the core
    input  wire logic        req_valid_in,
    input  wire logic [1:0]  req_kind_in,
    input  wire logic [15:0] req_addr_in,
    input  wire logic [7:0]  req_wdata_in,
    output logic             req_ready_out,
    // answer to the core
    output logic             resp_valid_out,
    output logic [7:0]       resp_rdata_out,
    output logic             bus_reset_out,
    // memory bus pins
    output logic             program_fetch_strobe_n_out,
    output logic             addr_latch_strobe_out,
    output logic             data_read_strobe_n_out,
    output logic             data_write_strobe_n_out,
    output logic [7:0]       upper_address_port_out,
    input  wire logic [7:0]  muxed_low_bus_in,
    output logic [7:0]       muxed_low_bus_out,
    output logic             muxed_low_bus_oe_out
);

    localparam int POR_W = $clog2(POR_TICKS + 1);

    // phase bounds of the latch strobe and data strobe windows
    localparam int              PH_W         = embs_pkg::PHASE_W;
    localparam logic [PH_W-1:0] ALE_END_PH   = PH_W'(embs_pkg::ALE_TICKS);
    localparam logic [PH_W-1:0] STB_START_PH = PH_W'(embs_pkg::STROBE_START);
    localparam logic [PH_W-1:0] STB_END_PH   = PH_W'(embs_pkg::STROBE_END);

    typedef struct packed {
        logic [1:0]             rst_sync;
        logic [POR_W-1:0]       por_cnt;
        embs_pkg::embs_kind_e   kind;
        logic [15:0]            addr;
        logic [7:0]             wdata;
        logic [7:0]             rdata;
        logic                   resp_valid;
        logic                   ale;
        logic                   fetch_n;
        logic                   rd_n;
        logic                   wr_n;
        logic [7:0]             upper;
        logic [7:0]             ad_out;
        logic                   ad_oe;
        logic [7:0]             din_meta;
        logic [7:0]             din_sync;
    } embs_state_s;

    embs_state_s state;
    embs_state_s next_state;

    logic [embs_pkg::PHASE_W-1:0] phase;
    logic                         period_end;
    logic                         bus_reset;
    logic                         in_ale;
    logic                         in_strobe;
    logic                         take;
    logic                         is_fetch;
    logic                         is_read;
    logic                         is_write;
    logic                         is_busy;

    // reset pin sync plus power-up stretch; no outside RC needed
    assign bus_reset = state.rst_sync[1] || (state.por_cnt != POR_W'(POR_TICKS));

    embs_phase_gen #(
        .PERIOD         (embs_pkg::PERIOD_TICKS)
    ) u_phase (
        .clk_in         (clk_in),
        .rst_n_in       (rst_n_in),
        .ce_in          (ce_in),
        .hold_in        (bus_reset),
        .phase_out      (phase),
        .period_end_out (period_end)
    );

    assign in_ale    = phase < ALE_END_PH;
    assign in_strobe = (phase >= STB_START_PH)
                    && (phase < STB_END_PH);

    // kind of the period now on the bus
    assign is_fetch  = (state.kind == embs_pkg::EMBS_FETCH);
    assign is_read   = (state.kind == embs_pkg::EMBS_READ);
    assign is_write  = (state.kind == embs_pkg::EMBS_WRITE);
    assign is_busy   = (state.kind != embs_pkg::EMBS_IDLE);

    // requests start only on a period boundary, so strobes never get clipped
    // gated by ce_in: a frozen bus must not accept a request it cannot start
    assign req_ready_out = period_end && ce_in;
    assign take          = req_valid_in && req_ready_out;

    // one bus period on the pins (each pin shows what the previous phase decided):
    //   phase 1..6   latch strobe high, address bytes driven on both ports
    //   phase 7..15  fetch, read or write strobe low; port released unless writing
    //   phase 13     pin byte enters the two-flop synchroniser
    //   phase 15     that byte is captured and the response raised; strobe rises next
    //   phase 0      write byte held one more tick as hold time for the memory
    //   the latch strobe keeps its four-clock period through idle periods too

    always_comb begin
        next_state          = state;
        next_state.rst_sync = {state.rst_sync[0], reset_pin_in};
        next_state.din_meta = muxed_low_bus_in;
        next_state.din_sync = state.din_meta;
        next_state.resp_valid = 1'b0;
        if (state.por_cnt != POR_W'(POR_TICKS)) begin
            next_state.por_cnt = state.por_cnt + POR_W'(1);
        end

        if (bus_reset) begin
            next_state.kind    = embs_pkg::EMBS_IDLE;
            next_state.ale     = 1'b1;
            next_state.fetch_n = 1'b1;
            next_state.rd_n    = 1'b1;
            next_state.wr_n    = 1'b1;
            next_state.upper   = embs_pkg::PORT_RESET_VALUE;
            next_state.ad_out  = embs_pkg::PORT_RESET_VALUE;
            next_state.ad_oe   = 1'b1;
        end else begin
            next_state.ale     = in_ale;
            // fetch strobe stays high for data cycles and idle periods
            next_state.fetch_n = !(in_strobe && is_fetch);
            next_state.rd_n    = !(in_strobe && is_read);
            next_state.wr_n    = !(in_strobe && is_write);
            if (in_ale) begin
                next_state.ad_out = state.addr[7:0];
                next_state.ad_oe  = 1'b1;
            end else if (is_write) begin
                next_state.ad_out = state.wdata;
                next_state.ad_oe  = 1'b1;
            end else begin
                // released for read data; port has no software latch
                next_state.ad_oe  = 1'b0;
            end
            next_state.upper = state.addr[15:8];

            if (period_end) begin
                if (is_fetch || is_read) begin
                    // last tick with the strobe low: data has settled at the pins
                    next_state.rdata = state.din_sync;
                end
                next_state.resp_valid = is_busy;
                next_state.kind       = embs_pkg::EMBS_IDLE;
                if (take) begin
                    next_state.kind  = embs_pkg::embs_kind_e'(req_kind_in);
                    next_state.addr  = req_addr_in;
                    next_state.wdata = req_wdata_in;
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            // every pin at its reset level from the first reset edge on
            state.rst_sync   <= 2'h0;
            state.por_cnt    <= '0;
            state.kind       <= embs_pkg::EMBS_IDLE;
            state.addr       <= 16'h0000;
            state.wdata      <= 8'h00;
            state.rdata      <= 8'h00;
            state.resp_valid <= 1'b0;
            state.ale        <= 1'b1;
            state.fetch_n    <= 1'b1;
            state.rd_n       <= 1'b1;
            state.wr_n       <= 1'b1;
            state.upper      <= embs_pkg::PORT_RESET_VALUE;
            state.ad_out     <= embs_pkg::PORT_RESET_VALUE;
            state.ad_oe      <= 1'b1;
            state.din_meta   <= 8'h00;
            state.din_sync   <= 8'h00;
        end else if (ce_in) begin
            state <= next_state;
        end
    end

    // core side
    assign resp_valid_out             = state.resp_valid;
    assign resp_rdata_out             = state.rdata;
    assign bus_reset_out              = bus_reset;

    // memory bus pins
    assign program_fetch_strobe_n_out = state.fetch_n;
    assign addr_latch_strobe_out      = state.ale;
    assign data_read_strobe_n_out     = state.rd_n;
    assign data_write_strobe_n_out    = state.wr_n;
    assign upper_address_port_out     = state.upper;
    assign muxed_low_bus_out          = state.ad_out;
    assign muxed_low_bus_oe_out       = state.ad_oe;

endmodule : embs_bus

// *** rtl/embs_pkg.sv ***
// Purpose: shared constants and types for the external memory bus strobe block
// Assumes: clk_in runs at four ticks per crystal input clock (quarter-clock resolution)
// Notes:   all strobe widths are stated in hundredths of a crystal clock
package embs_pkg;

    // timing base: one tick is a quarter crystal clock
    localparam int TICKS_PER_XTAL   = 4;
    localparam int XTAL_PER_PERIOD  = 4;
    localparam int PERIOD_TICKS     = TICKS_PER_XTAL * XTAL_PER_PERIOD;
    localparam int PHASE_W          = $clog2(PERIOD_TICKS);

    // strobe widths in hundredths of a crystal clock
    localparam int ALE_HIGH_CENTI   = 150;
    localparam int FETCH_LOW_CENTI  = 225;
    localparam int ALE_TICKS        = (ALE_HIGH_CENTI * TICKS_PER_XTAL) / 100;
    localparam int STROBE_TICKS     = (FETCH_LOW_CENTI * TICKS_PER_XTAL) / 100;

    // strobe placement inside a bus period
    localparam int STROBE_START     = ALE_TICKS;
    localparam int STROBE_END       = STROBE_START + STROBE_TICKS;
    localparam int LAST_PHASE       = PERIOD_TICKS - 1;

    // internal power-up reset stretch, in ticks
    localparam int POR_TICKS        = 16;

    // pin levels after reset
    localparam logic [7:0] PORT_RESET_VALUE = 8'hFF;

    typedef enum logic [1:0] {
        EMBS_IDLE  = 2'b00,
        EMBS_FETCH = 2'b01,
        EMBS_READ  = 2'b10,
        EMBS_WRITE = 2'b11
    } embs_kind_e;

endpackage : embs_pkg

// *** rtl/embs_phase_gen.sv ***
// Purpose: bus period phase counter, wraps every four crystal clocks
// Assumes: clk_in ticks at quarter crystal clock resolution
// Notes:   held at phase zero while the bus is in reset
`timescale 1ns/1ns
module embs_phase_gen #(
    parameter int PERIOD = embs_pkg::PERIOD_TICKS
) (
    // clock and control
    input  wire logic                         clk_in,
    input  wire logic                         rst_n_in,
    input  wire logic                         ce_in,
    input  wire logic                         hold_in,
    // phase
    output logic [embs_pkg::PHASE_W-1:0]      phase_out,
    output logic                              period_end_out
);

    typedef struct packed {
        logic [embs_pkg::PHASE_W-1:0] phase;
    } embs_phase_s;

    embs_phase_s state;
    embs_phase_s next_state;

    always_comb begin
        next_state = state;
        if (hold_in) begin
            next_state.phase = '0;
        end else if (state.phase == embs_pkg::PHASE_W'(PERIOD - 1)) begin
            next_state.phase = '0;
        end else begin
            next_state.phase = state.phase + embs_pkg::PHASE_W'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state <= '0;
        end else if (ce_in) begin
            state <= next_state;
        end
    end

    assign phase_out      = state.phase;
    assign period_end_out = (state.phase == embs_pkg::PHASE_W'(PERIOD - 1)) && !hold_in;

endmodule : embs_phase_gen

// *** verif/embs_bus_asserts.sv ***
// Purpose: pin timing checks for embs_bus
// Assumes: ce_in held high, so every tick advances the phase
// Notes:   most checks pause while the bus sits in reset
`timescale 1ns/1ns
module embs_bus_asserts (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // core side
    input  wire logic        req_valid_in,
    input  wire logic [1:0]  req_kind_in,
    input  wire logic [15:0] req_addr_in,
    input  wire logic        req_ready_out,
    input  wire logic        resp_valid_out,
    input  wire logic        bus_reset_out,
    // memory pins
    input  wire logic        program_fetch_strobe_n_out,
    input  wire logic        addr_latch_strobe_out,
    input  wire logic        data_read_strobe_n_out,
    input  wire logic        data_write_strobe_n_out,
    input  wire logic [7:0]  upper_address_port_out,
    input  wire logic [7:0]  muxed_low_bus_out,
    input  wire logic        muxed_low_bus_oe_out
);
    logic        ale, pf, oe, take;
    logic [15:0] addr;
    assign ale = addr_latch_strobe_out;
    assign pf = program_fetch_strobe_n_out;
    assign oe = muxed_low_bus_oe_out;
    assign take = req_valid_in && req_ready_out && req_kind_in != 2'h0;
    always_ff @(posedge clk_in) begin
        if (take) begin
            addr <= req_addr_in;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in || bus_reset_out);
    ale_width_a: assert property ($rose(ale) |-> ale [*6] ##1 !ale)
        else $error("latch strobe width wrong");
    ale_period_a: assert property ($rose(ale) |-> ##16 $rose(ale))
        else $error("latch strobe period wrong");
    fetch_width_a: assert property ($fell(pf) |-> !pf [*8] ##1 !pf ##1 pf)
        else $error("fetch strobe width wrong");
    fetch_quiet_a: assert property (!data_read_strobe_n_out
        || !data_write_strobe_n_out |-> pf)
        else $error("fetch strobe low in data access");
    reset_pins_a: assert property (disable iff (!rst_n_in)
        bus_reset_out && $past(bus_reset_out) |-> ale && pf && oe && muxed_low_bus_out == 8'hFF)
        else $error("pins not at reset level");
    addr_phase_a: assert property (take |-> ##2 ale && oe
        && muxed_low_bus_out == addr[7:0] && upper_address_port_out == addr[15:8])
        else $error("address not on port");
    port_turn_a: assert property ($fell(ale) |-> !oe || !data_write_strobe_n_out)
        else $error("port still driven after latch strobe");
    resp_time_a: assert property (take |-> ##17 resp_valid_out)
        else $error("response late");
    ready_space_a: assert property (req_ready_out |=> !req_ready_out ##15 req_ready_out)
        else $error("ready spacing wrong");
endmodule : embs_bus_asserts

// *** verif/embs_mem_model.sv ***
// Purpose: outside address latch, program ROM and data RAM
// Assumes: ROM byte is a fixed mix of its address so every fetch can be checked
// Notes:   no pull-ups: a released bus shows the inverse of its last level
`timescale 1ns/1ns
module embs_mem_model (
    // clock and strobes
    input  wire logic       clk_in,
    input  wire logic       ale_in,
    input  wire logic       fetch_n_in,
    input  wire logic       rd_n_in,
    input  wire logic       wr_n_in,
    // address and data
    input  wire logic [7:0] upper_in,
    input  wire logic [7:0] bus_in,
    output logic      [7:0] bus_out
);
    logic [7:0] low;
    logic [7:0] last;
    logic [7:0] ram [0:255];
    always @(posedge clk_in) last <= bus_in;
    // latch from last tick's level: stands in for the latch hold time at strobe fall
    always_latch begin
        if (ale_in) begin
            low <= last;
        end
    end
    always @(posedge wr_n_in) ram[low] <= bus_in;
    always_comb begin
        bus_out = !fetch_n_in ? (upper_in ^ low ^ 8'h5A) : (!rd_n_in ? ram[low] : ~last);
    end
endmodule : embs_mem_model

// *** verif/embs_bus_tb.sv ***
// Purpose: directed test of the memory bus strobes against a memory model
// Assumes: ce_in tied high; short power-up stretch
// Notes:   inputs change at the falling edge only
`timescale 1ns/1ns
module embs_bus_tb;
    logic        clk_in, rst_n_in, reset_pin_in, req_valid_in, req_ready_out, resp_valid_out;
    logic        bus_reset_out, pf_n, ale, rd_n, wr_n, oe;
    logic [1:0]  req_kind_in;
    logic [15:0] req_addr_in;
    logic [7:0]  req_wdata_in, resp_rdata_out, upper, dut_out, mem_out, bus;
    int          miscompares, n_checks;
    assign bus = oe ? dut_out : mem_out;
    embs_bus #(.POR_TICKS(2)) i_dut (.clk_in, .rst_n_in, .ce_in(1'b1), .reset_pin_in,
        .req_valid_in, .req_kind_in, .req_addr_in, .req_wdata_in, .req_ready_out,
        .resp_valid_out, .resp_rdata_out, .bus_reset_out, .program_fetch_strobe_n_out(pf_n),
        .addr_latch_strobe_out(ale), .data_read_strobe_n_out(rd_n),
        .data_write_strobe_n_out(wr_n), .upper_address_port_out(upper),
        .muxed_low_bus_in(bus), .muxed_low_bus_out(dut_out), .muxed_low_bus_oe_out(oe));
    embs_mem_model i_mem (.clk_in, .ale_in(ale), .fetch_n_in(pf_n), .rd_n_in(rd_n),
        .wr_n_in(wr_n), .upper_in(upper), .bus_in(bus), .bus_out(mem_out));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    task automatic bus_op(input logic [1:0] kind, input logic [15:0] addr, input logic [7:0] wd);
        int i;
        req_valid_in = 1'b1;
        req_kind_in = kind;
        req_addr_in = addr;
        req_wdata_in = wd;
        for (i = 0; i < 40 && req_ready_out !== 1'b1; i++) @(negedge clk_in);
        @(negedge clk_in);
        req_valid_in = 1'b0;
        for (i = 0; i < 40 && resp_valid_out !== 1'b1; i++) @(negedge clk_in);
        check(resp_valid_out, 1'b1);
    endtask : bus_op
    task automatic wait_run;
        int i;
        for (i = 0; i < 40 && bus_reset_out !== 1'b0; i++) @(negedge clk_in);
        check(bus_reset_out, 1'b0);
    endtask : wait_run
    task automatic test_reset;
        check({bus_reset_out, ale, pf_n, oe}, 4'hF);
        check(dut_out, 8'hFF);
        wait_run();
    endtask : test_reset
    task automatic test_fetch;
        bus_op(2'h1, 16'hA53C, 8'h00);
        check(resp_rdata_out, 8'hA5 ^ 8'h3C ^ 8'h5A);
        bus_op(2'h1, 16'h00FF, 8'h00);
        check(resp_rdata_out, 8'hFF ^ 8'h5A);
    endtask : test_fetch
    task automatic test_data;
        bus_op(2'h3, 16'h1234, 8'h96);
        bus_op(2'h2, 16'h1234, 8'h00);
        check(resp_rdata_out, 8'h96);
    endtask : test_data
    task automatic test_idle;
        int          i;
        logic [15:0] seen;
        seen = 16'h0000;
        req_valid_in = 1'b1;
        req_kind_in = 2'h0;
        for (i = 0; i < 40 && req_ready_out !== 1'b1; i++) @(negedge clk_in);
        @(negedge clk_in);
        req_valid_in = 1'b0;
        repeat (20) begin
            @(negedge clk_in);
            if ({resp_valid_out, pf_n, rd_n, wr_n} !== 4'h7) seen++;
        end
        check(seen, 16'h0000);
    endtask : test_idle
    task automatic test_pin;
        reset_pin_in = 1'b1;
        repeat (6) @(negedge clk_in);
        check({bus_reset_out, ale, pf_n}, 3'h7);
        reset_pin_in = 1'b0;
        wait_run();
        bus_op(2'h1, 16'h5A5A, 8'h00);
        check(resp_rdata_out, 8'h5A);
    endtask : test_pin
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    initial begin
        repeat (3000) @(posedge clk_in);
        miscompares++;
        wrap_up();
    end
    initial begin
        {rst_n_in, reset_pin_in, req_valid_in, req_kind_in} = 5'h00;
        req_addr_in = 16'h0000;
        req_wdata_in = 8'h00;
        repeat (10) @(negedge clk_in);
        rst_n_in = 1'b1;
        test_reset();
        test_fetch();
        test_data();
        test_idle();
        test_pin();
        wrap_up();
    end
endmodule : embs_bus_tb
bind embs_bus embs_bus_asserts u_chk (.clk_in, .rst_n_in, .req_valid_in, .req_kind_in,
    .req_addr_in, .req_ready_out, .resp_valid_out, .bus_reset_out, .program_fetch_strobe_n_out,
    .addr_latch_strobe_out, .data_read_strobe_n_out, .data_write_strobe_n_out,
    .upper_address_port_out, .muxed_low_bus_out, .muxed_low_bus_oe_out);
